// ===== hw/t1ts_cfg.svh
// Offsets, field positions, reset values and framing counts of the
// transmit frame synchronizer. Included by the package and the top module.
`ifndef T1TS_CFG_SVH
`define T1TS_CFG_SVH

// Register indices; byte address is four times the index
`define T1TS_CTRL_IDX 16'h018E
`define T1TS_STS_IDX 16'h0192
`define T1TS_MASK_IDX 16'h01A2
`define T1TS_AUX_IDX 16'h01F0
`define T1TS_PORT_STRIDE 16'h0200
`define T1TS_NPORTS 4

// Control fields
`define T1TS_CTRL_RESYNC 0
`define T1TS_CTRL_INHIBIT 1
`define T1TS_CTRL_ENABLE 2
// Status fields
`define T1TS_STS_LATCHED 0
`define T1TS_STS_ACTIVE 1
// Auxiliary configuration fields
`define T1TS_AUX_MFSEL 0
`define T1TS_AUX_PINDIR 1
`define T1TS_AUX_ESF 2

// Reset values
`define T1TS_CTRL_RST 3'h0
`define T1TS_MASK_RST 1'h0
`define T1TS_AUX_RST 3'h0

// Framing counts
`define T1TS_FRAME_LAST 8'hC0
`define T1TS_D4_LAST 5'h0B
`define T1TS_ESF_LAST 5'h17
`define T1TS_ERR_LIMIT 2'h2
`define T1TS_D4_PATTERN 12'h3B1
`define T1TS_ESF_PATTERN 6'h34

// Bus responses
`define T1TS_RESP_OKAY 2'h0
`define T1TS_RESP_SLVERR 2'h2

`endif

// ===== hw/t1ts_pkg.sv
// Types of the transmit frame synchronizer: states and the state record.
// Assumes the constants header is on the include path.
`include "t1ts_cfg.svh"

package t1ts_pkg;

    // Alignment search states, one-hot
    typedef enum logic [2:0] {
        T1TS_IDLE = 3'b001,
        T1TS_HUNT = 3'b010,
        T1TS_LOCK = 3'b100
    } t1ts_state_t;

    // State of one line port
    typedef struct packed {
        logic [2:0] ctrl;      // Enable, inhibit, resync
        logic latched;         // Sticky loss of frame
        logic mask;            // Interrupt mask
        logic [2:0] aux;       // Esf, pin direction, multiframe select
        t1ts_state_t state;    // Search state
        logic [7:0] bit_cnt;   // Bit within frame
        logic [4:0] frm_cnt;   // Frame within multiframe
        logic [1:0] err_cnt;   // Framing errors this multiframe
        logic [2:0] dat_s;     // Data synchroniser
        logic [2:0] clk_s;     // Bit clock synchroniser
        logic clk_f;           // Filtered bit clock
        logic pulse;           // Sync pin output
        logic pulse_oe;        // Sync pin enable
    } t1ts_port_t;

    // Whole block state
    typedef struct packed {
        t1ts_port_t [`T1TS_NPORTS-1:0] port;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } t1ts_top_t;

    // Decoded register address
    typedef struct packed {
        logic hit;
        logic [1:0] port;
        logic [1:0] sel;
    } t1ts_dec_t;

endpackage : t1ts_pkg

// ===== hw/t1ts_sync.sv
// Four-port T1 transmit frame synchronizer with AXI4-Lite registers.
// Assumes a 200 MHz clock, synchronous reset, and per-port serial data
// with its bit clock arriving asynchronously from the backplane.
//
// Operation
// - Locate D4 or ESF boundary when enabled
// - Frame-mode bit picks D4 or ESF pattern
// - Real-time bit high while searching
// - Latched bit set on entering search
// - Masked latched bit drives interrupt
// - Drive recovered frame pulse on pin
// - Multiframe pulse instead when selected
// - Control bit two enables, resets off
// - Control bit one inhibits auto resync
// - Rising resync bit starts new search
// - Per-port registers at port stride
`timescale 1ns/1ps
`default_nettype none
`include "t1ts_cfg.svh"

module t1ts_sync
    import t1ts_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    // Backplane serial inputs
    input wire logic [`T1TS_NPORTS-1:0] tx_serial_data_in_i,
    input wire logic [`T1TS_NPORTS-1:0] tx_bit_clk_i,
    // Sync pins
    output logic [`T1TS_NPORTS-1:0] tx_frame_pulse_pin_o,
    output logic [`T1TS_NPORTS-1:0] tx_frame_pulse_pin_oe_o,
    output logic irq_o,
    // AXI4-Lite slave
    input wire logic [15:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [15:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    t1ts_top_t state_reg;  // Registered state
    t1ts_top_t state_next; // Next state

    // Map a byte address to port and register
    function automatic t1ts_dec_t decode(input logic [15:0] addr);
        t1ts_dec_t d;
        logic [15:0] base;
        d = '0;
        for (int n = 0; n < `T1TS_NPORTS; n++)
        begin
            base = 16'(n) * `T1TS_PORT_STRIDE;
            if (addr == 16'((`T1TS_CTRL_IDX + base) << 2))
            begin
                d = '{hit: 1'b1, port: 2'(n), sel: 2'h0};
            end
            if (addr == 16'((`T1TS_STS_IDX + base) << 2))
            begin
                d = '{hit: 1'b1, port: 2'(n), sel: 2'h1};
            end
            if (addr == 16'((`T1TS_MASK_IDX + base) << 2))
            begin
                d = '{hit: 1'b1, port: 2'(n), sel: 2'h2};
            end
            if (addr == 16'((`T1TS_AUX_IDX + base) << 2))
            begin
                d = '{hit: 1'b1, port: 2'(n), sel: 2'h3};
            end
        end
        return d;
    endfunction : decode

    // Expected framing bit: {checked, value} for a frame of the multiframe
    function automatic logic [1:0] fpat(input logic esf, input logic [4:0] frm);
        logic [5:0] esf_pat;
        logic [11:0] d4_pat;
        esf_pat = `T1TS_ESF_PATTERN;
        d4_pat = `T1TS_D4_PATTERN;
        if (esf)
        begin
            // Only every fourth frame carries the alignment bit
            fpat = {(frm[1:0] == 2'h3), esf_pat[frm[4:2]]};
        end
        else
        begin
            fpat = {1'b1, d4_pat[frm[3:0]]};
        end
    endfunction : fpat

    // Read value of one register
    function automatic logic [31:0] rd_value(input t1ts_port_t p, input logic [1:0] sel);
        case (sel)
            2'h0: rd_value = {29'h0, p.ctrl};
            2'h1: rd_value = {30'h0, (p.state == T1TS_HUNT), p.latched};
            2'h2: rd_value = {31'h0, p.mask};
            default: rd_value = {29'h0, p.aux};
        endcase
    endfunction : rd_value

    // Next-state logic for framing, registers and bus
    always_comb
    begin
        t1ts_dec_t wdec;
        t1ts_dec_t rdec;
        t1ts_port_t p;
        logic stb;
        logic fbit;
        logic [1:0] exp_f;
        logic [4:0] last_frm;
        logic wr_go;
        logic irq_any;
        wdec = decode(s_axi_awaddr_i);
        rdec = decode(s_axi_araddr_i);
        p = '0;
        stb = 1'b0;
        fbit = 1'b0;
        exp_f = 2'h0;
        last_frm = 5'h0;
        irq_any = 1'b0;
        state_next = state_reg;
        // Write taken when address and data arrive together
        wr_go = state_reg.awready & s_axi_awvalid_i & s_axi_wvalid_i;

        for (int n = 0; n < `T1TS_NPORTS; n++)
        begin
            p = state_reg.port[n];
            // Three-stage synchronisers; the bit clock's second and third stages must agree
            p.dat_s = {p.dat_s[1:0], tx_serial_data_in_i[n]};
            p.clk_s = {p.clk_s[1:0], tx_bit_clk_i[n]};
            stb = 1'b0;
            if (state_reg.port[n].clk_s[2] == state_reg.port[n].clk_s[1])
            begin
                stb = state_reg.port[n].clk_s[2] & ~state_reg.port[n].clk_f;
                p.clk_f = state_reg.port[n].clk_s[2];
            end
            fbit = state_reg.port[n].dat_s[2];
            exp_f = fpat(p.aux[`T1TS_AUX_ESF], p.frm_cnt);
            last_frm = p.aux[`T1TS_AUX_ESF] ? `T1TS_ESF_LAST : `T1TS_D4_LAST;
            p.pulse = 1'b0;
            p.pulse_oe = p.aux[`T1TS_AUX_PINDIR];

            if (!p.ctrl[`T1TS_CTRL_ENABLE])
            begin
                // Disabled: idle, counters cleared
                p.state = T1TS_IDLE;
                p.bit_cnt = 8'h0;
                p.frm_cnt = 5'h0;
                p.err_cnt = 2'h0;
            end
            else if (stb)
            begin
                case (p.state)
                    T1TS_IDLE:
                    begin
                        // Enabled: start hunting at the next bit
                        p.state = T1TS_HUNT;
                    end
                    T1TS_HUNT:
                    begin
                        if (p.bit_cnt == 8'h0)
                        begin
                            if (exp_f[1] && fbit != exp_f[0])
                            begin
                                // Mismatch: slip one bit, restart multiframe
                                p.frm_cnt = 5'h0;
                            end
                            else
                            begin
                                p.bit_cnt = 8'h1;
                                if (p.frm_cnt == last_frm)
                                begin
                                    // Whole multiframe matched
                                    p.state = T1TS_LOCK;
                                    p.frm_cnt = 5'h0;
                                    p.err_cnt = 2'h0;
                                end
                                else
                                begin
                                    p.frm_cnt = p.frm_cnt + 5'h1;
                                end
                            end
                        end
                        else
                        begin
                            p.bit_cnt = (p.bit_cnt == `T1TS_FRAME_LAST) ? 8'h0 : p.bit_cnt + 8'h1;
                        end
                    end
                    T1TS_LOCK:
                    begin
                        if (p.bit_cnt == 8'h0)
                        begin
                            // Frame or multiframe pulse on the pin
                            p.pulse = ~p.aux[`T1TS_AUX_MFSEL] | (p.frm_cnt == 5'h0);
                            if (exp_f[1] && fbit != exp_f[0])
                            begin
                                p.err_cnt = p.err_cnt + 2'h1;
                            end
                            if (p.err_cnt == `T1TS_ERR_LIMIT && !p.ctrl[`T1TS_CTRL_INHIBIT])
                            begin
                                // Frame lost: automatic resync
                                p.state = T1TS_HUNT;
                                p.frm_cnt = 5'h0;
                                p.err_cnt = 2'h0;
                            end
                            else if (p.frm_cnt == last_frm)
                            begin
                                p.frm_cnt = 5'h0;
                                p.err_cnt = 2'h0;
                                p.bit_cnt = 8'h1;
                            end
                            else
                            begin
                                p.frm_cnt = p.frm_cnt + 5'h1;
                                p.bit_cnt = 8'h1;
                            end
                        end
                        else
                        begin
                            p.bit_cnt = (p.bit_cnt == `T1TS_FRAME_LAST) ? 8'h0 : p.bit_cnt + 8'h1;
                        end
                    end
                    default:
                    begin
                        p.state = T1TS_IDLE;
                    end
                endcase
            end

            // Register writes to this port
            if (wr_go && wdec.hit && wdec.port == 2'(n) && s_axi_wstrb_i[0])
            begin
                case (wdec.sel)
                    2'h0:
                    begin
                        // Rising resync bit restarts the search
                        if (!p.ctrl[`T1TS_CTRL_RESYNC] && s_axi_wdata_i[`T1TS_CTRL_RESYNC]
                            && s_axi_wdata_i[`T1TS_CTRL_ENABLE])
                        begin
                            p.state = T1TS_HUNT;
                            p.bit_cnt = 8'h0;
                            p.frm_cnt = 5'h0;
                            p.err_cnt = 2'h0;
                        end
                        p.ctrl = s_axi_wdata_i[2:0];
                    end
                    2'h1:
                    begin
                        // Write one to clear
                        if (s_axi_wdata_i[`T1TS_STS_LATCHED])
                        begin
                            p.latched = 1'b0;
                        end
                    end
                    2'h2:
                    begin
                        p.mask = s_axi_wdata_i[0];
                    end
                    default:
                    begin
                        p.aux = s_axi_wdata_i[2:0];
                    end
                endcase
            end

            // Entering a search sets the sticky flag; set beats clear
            if (p.state == T1TS_HUNT && state_reg.port[n].state != T1TS_HUNT)
            begin
                p.latched = 1'b1;
            end
            irq_any = irq_any | (p.latched & p.mask);
            state_next.port[n] = p;
        end
        state_next.irq = irq_any;

        // Write channel: one-cycle ready when both offered, then response
        state_next.awready = 1'b0;
        state_next.wready = 1'b0;
        if (state_reg.bvalid && s_axi_bready_i)
        begin
            state_next.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            state_next.bvalid = 1'b1;
            state_next.bresp = wdec.hit ? `T1TS_RESP_OKAY : `T1TS_RESP_SLVERR;
        end
        else if (!state_reg.awready && !state_reg.bvalid && s_axi_awvalid_i && s_axi_wvalid_i)
        begin
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
        end

        // Read channel: one-cycle ready, then data
        state_next.arready = 1'b0;
        if (state_reg.rvalid && s_axi_rready_i)
        begin
            state_next.rvalid = 1'b0;
        end
        if (state_reg.arready && s_axi_arvalid_i)
        begin
            state_next.rvalid = 1'b1;
            state_next.rdata = rdec.hit ? rd_value(state_reg.port[rdec.port], rdec.sel) : 32'h0;
            state_next.rresp = rdec.hit ? `T1TS_RESP_OKAY : `T1TS_RESP_SLVERR;
        end
        else if (!state_reg.arready && !state_reg.rvalid && s_axi_arvalid_i)
        begin
            state_next.arready = 1'b1;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            for (int n = 0; n < `T1TS_NPORTS; n++)
            begin
                state_reg.port[n].ctrl <= `T1TS_CTRL_RST;
                state_reg.port[n].mask <= `T1TS_MASK_RST;
                state_reg.port[n].aux <= `T1TS_AUX_RST;
                state_reg.port[n].state <= T1TS_IDLE;
            end
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    always_comb
    begin
        for (int n = 0; n < `T1TS_NPORTS; n++)
        begin
            tx_frame_pulse_pin_o[n] = state_reg.port[n].pulse;
            tx_frame_pulse_pin_oe_o[n] = state_reg.port[n].pulse_oe;
        end
        irq_o = state_reg.irq;
        s_axi_awready_o = state_reg.awready;
        s_axi_wready_o = state_reg.wready;
        s_axi_bvalid_o = state_reg.bvalid;
        s_axi_bresp_o = state_reg.bresp;
        s_axi_arready_o = state_reg.arready;
        s_axi_rvalid_o = state_reg.rvalid;
        s_axi_rdata_o = state_reg.rdata;
        s_axi_rresp_o = state_reg.rresp;
    end

endmodule : t1ts_sync

`default_nettype wire

// ===== testbench/t1_transmit_frame_synchronizer_bench.sv
// Bench of the four-port transmit frame synchronizer.
// Assumes the design, its package, header, checker and backplane model.
`timescale 1ns/1ps
`default_nettype none
`include "t1ts_cfg.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", n, e, s); end end

module t1_transmit_frame_synchronizer_bench;
    import t1ts_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] bclk, ser, pin, oe;
    logic irq, awrdy, wrdy, bv, arrdy, rv;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [15:0] awa = 16'h0000, ara = 16'h0000;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] br, rr, r;
    logic [1:0] mode [4] = '{default: 2'h0}; // Partner modes
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int v;

    always #2.5 clk = ~clk;

    // One backplane model per port
    for (genvar i = 0; i < 4; i++)
    begin : g_bp
        t1ts_backplane u_bp (.clock_i(clk), .rst_i(rst), .mode_i(mode[i]), .bit_clk_o(bclk[i]), .data_o(ser[i]));
    end

    t1ts_sync u_dut (.clock_i(clk), .rst_i(rst), .tx_serial_data_in_i(ser), .tx_bit_clk_i(bclk),
        .tx_frame_pulse_pin_o(pin), .tx_frame_pulse_pin_oe_o(oe), .irq_o(irq),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(1'b1));

    // Byte address of a port register
    function automatic logic [15:0] ra(input int p, input logic [15:0] idx);
        return 16'(4 * (idx + p * `T1TS_PORT_STRIDE));
    endfunction : ra

    // Write: both channels offered, each released when taken
    task automatic wr(input logic [15:0] a, input logic [31:0] dv, output logic [1:0] rsp);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awa <= a;
        wd <= dv;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awrdy === 1'b1) awv <= 1'b0;
            if (wrdy === 1'b1) wv <= 1'b0;
            ad |= (awrdy === 1'b1);
            dd |= (wrdy === 1'b1);
        end
        while (!(ad && dd));
        do @(posedge clk); while (bv !== 1'b1);
        rsp = br;
    endtask : wr

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [15:0] a, output logic [31:0] dv, output logic [1:0] rsp);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (arrdy !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        dv = rdat;
        rsp = rr;
    endtask : rd

    task automatic wreg(input int p, input logic [15:0] idx, input logic [31:0] dv);
        wr(ra(p, idx), dv, r);
        `CHK("write response", `T1TS_RESP_OKAY, r)
    endtask : wreg

    task automatic rchk(input string n, input int p, input logic [15:0] idx, input logic [31:0] e);
        rd(ra(p, idx), d, r);
        `CHK(n, e, d)
        `CHK("read response", `T1TS_RESP_OKAY, r)
    endtask : rchk

    // Poll the searching bit until it shows the wanted level
    task automatic wait_sts(input int p, input logic b);
        do
        begin
            repeat (200) @(posedge clk);
            rd(ra(p, `T1TS_STS_IDX), d, r);
        end
        while (d[1] !== b);
    endtask : wait_sts

    // Cycles between two frame pulses of one port
    task automatic gap(input int p, input int e);
        int n;
        n = 1;
        while (pin[p] !== 1'b1) @(posedge clk);
        @(posedge clk);
        while (pin[p] !== 1'b1)
        begin
            n++;
            @(posedge clk);
        end
        `CHK("pulse gap", e, n)
    endtask : gap

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // Ceiling: about forty frames to lock plus two multiframes of pulses
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            failures++;
            tally_and_finish;
        end
    end

    initial
    begin
        void'($urandom(47));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values on random ports
        repeat (4)
        begin
            v = $urandom % 4;
            rchk("control", v, `T1TS_CTRL_IDX, 32'h0);
            rchk("status", v, `T1TS_STS_IDX, 32'h0);
            rchk("mask", v, `T1TS_MASK_IDX, 32'h0);
        end
        // Unmapped place answers with an error
        rd(16'h0004, d, r);
        `CHK("unmapped data", 32'h0, d)
        `CHK("unmapped response", `T1TS_RESP_SLVERR, r)
        wr(16'h0008, 32'h1, r);
        `CHK("unmapped write", `T1TS_RESP_SLVERR, r)
        // D4, ESF, D4 with multiframe pulse and inhibit, idle
        mode <= '{2'h1, 2'h2, 2'h1, 2'h0};
        wreg(0, `T1TS_AUX_IDX, 32'h2);
        wreg(1, `T1TS_AUX_IDX, 32'h6);
        wreg(2, `T1TS_AUX_IDX, 32'h3);
        v = $urandom % 2;
        wreg(3, `T1TS_MASK_IDX, 32'(v));
        rchk("mask", 3, `T1TS_MASK_IDX, 32'(v));
        wreg(0, `T1TS_CTRL_IDX, 32'h4);
        wreg(1, `T1TS_CTRL_IDX, 32'h4);
        wreg(2, `T1TS_CTRL_IDX, 32'h6);
        repeat (40) @(posedge clk);
        rchk("status", 0, `T1TS_STS_IDX, 32'h3);
        rchk("status", 3, `T1TS_STS_IDX, 32'h0);
        wreg(1, `T1TS_STS_IDX, 32'h2);
        rchk("status", 1, `T1TS_STS_IDX, 32'h3);
        `CHK("pin enable", 4'h7, oe)
        `CHK("interrupt", 1'b0, irq)
        // Lock, latched bit survives, then write one clears it
        wait_sts(0, 1'b0);
        wait_sts(2, 1'b0);
        rchk("status", 0, `T1TS_STS_IDX, 32'h1);
        wreg(0, `T1TS_STS_IDX, 32'h1);
        wreg(2, `T1TS_STS_IDX, 32'h1);
        rchk("status", 2, `T1TS_STS_IDX, 32'h0);
        fork
            gap(0, 193 * 6);
            gap(2, 12 * 193 * 6);
        join
        wreg(0, `T1TS_MASK_IDX, 32'h1);
        repeat (4) @(posedge clk);
        `CHK("interrupt", 1'b0, irq)
        // Corrupt data: port 0 hunts again, port 2 is inhibited
        mode[0] <= 2'h3;
        mode[2] <= 2'h3;
        wait_sts(0, 1'b1);
        repeat (4) @(posedge clk);
        `CHK("interrupt", 1'b1, irq)
        rchk("status", 0, `T1TS_STS_IDX, 32'h3);
        rchk("status", 2, `T1TS_STS_IDX, 32'h0);
        wreg(0, `T1TS_MASK_IDX, 32'h0);
        repeat (4) @(posedge clk);
        `CHK("interrupt", 1'b0, irq)
        wreg(2, `T1TS_CTRL_IDX, 32'h7);
        repeat (40) @(posedge clk);
        rchk("status", 2, `T1TS_STS_IDX, 32'h3);
        // ESF port locks; disabling a hunting port stops the search
        wait_sts(1, 1'b0);
        rchk("status", 1, `T1TS_STS_IDX, 32'h1);
        wreg(0, `T1TS_CTRL_IDX, 32'h0);
        repeat (40) @(posedge clk);
        rchk("status", 0, `T1TS_STS_IDX, 32'h1);
        tally_and_finish;
    end
endmodule : t1_transmit_frame_synchronizer_bench

bind t1ts_sync t1ts_sync_chk u_chk (.clock_i, .rst_i, .tx_frame_pulse_pin_o, .tx_frame_pulse_pin_oe_o, .irq_o,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rdata_o);

`default_nettype wire

// ===== testbench/t1ts_backplane.sv
// Backplane model of one port: bit clock and framed serial data.
// Assumes the bench changes the mode only between test phases.
`timescale 1ns/1ps
`default_nettype none
`include "t1ts_cfg.svh"

module t1ts_backplane (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i, // Idle, D4, ESF, random
    output logic bit_clk_o,
    output logic data_o
);
    logic [2:0] ph; // Phase within a six-cycle bit
    logic [7:0] pos; // Bit within frame
    logic [4:0] frm; // Frame within multiframe

    // Three cycles high, three low; data moves on the falling edge
    always @(posedge clock_i)
    begin
        if (rst_i || mode_i == 2'h0)
        begin
            // Idle: clock stands low, data keeps changing
            ph <= 3'h0;
            pos <= 8'h00;
            frm <= 5'h00;
            bit_clk_o <= 1'b0;
            data_o <= 1'($urandom);
        end
        else
        begin
            ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            bit_clk_o <= (ph < 3'h3);
            if (ph == 3'h3)
            begin
                // In D4 and ESF modes the whole frame carries its alignment bit value; random mode sends random bits
                case (mode_i)
                    2'h1: data_o <= 1'(`T1TS_D4_PATTERN >> frm);
                    2'h2: data_o <= 1'(`T1TS_ESF_PATTERN >> frm[4:2]);
                    default: data_o <= 1'($urandom);
                endcase
                pos <= (pos == `T1TS_FRAME_LAST) ? 8'h00 : pos + 8'h01;
                if (pos == `T1TS_FRAME_LAST)
                    frm <= (frm >= ((mode_i == 2'h2) ? `T1TS_ESF_LAST : `T1TS_D4_LAST)) ? 5'h00 : frm + 5'h01;
            end
        end
    end
endmodule : t1ts_backplane

`default_nettype wire

// ===== testbench/t1ts_sync_chk.sv
// Port-level assertions of the four-port transmit frame synchronizer.
// Assumes binding to the top module, one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "t1ts_cfg.svh"

module t1ts_sync_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [`T1TS_NPORTS-1:0] tx_frame_pulse_pin_o,
    input wire logic [`T1TS_NPORTS-1:0] tx_frame_pulse_pin_oe_o,
    input wire logic irq_o,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [31:0] s_axi_rdata_o
);
    // One domain, so one clocking and one disable
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Frame pulses last one cycle, and port 0 stays low for eight cycles after a pulse
    AST_PULSE_ONE: assert property (|tx_frame_pulse_pin_o |=>
        (tx_frame_pulse_pin_o & $past(tx_frame_pulse_pin_o)) == '0)
        else $error("frame pulse longer than one cycle");
    AST_PULSE_QUIET: assert property (tx_frame_pulse_pin_o[0] |=> !tx_frame_pulse_pin_o[0] [*8])
        else $error("frame pulses too close");
    // Pin direction only follows a register write
    AST_OE_BY_WRITE: assert property (!$stable(tx_frame_pulse_pin_oe_o) |->
        s_axi_bvalid_o || $past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2))
        else $error("pin enable moved without a write");
    // Interrupt is sticky: only a clear or mask write drops it
    AST_IRQ_STICKY: assert property ($fell(irq_o) |->
        s_axi_bvalid_o || $past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2))
        else $error("interrupt dropped without a write");
    // Write channels are taken together and only when offered
    AST_WR_PAIR: assert property (s_axi_awready_o == s_axi_wready_o)
        else $error("address and data ready differ");
    AST_WR_CAUSE: assert property (s_axi_awready_o |-> $past(s_axi_awvalid_i && s_axi_wvalid_i))
        else $error("write taken without request");
    AST_B_AFTER: assert property (s_axi_awready_o && s_axi_awvalid_i |=> s_axi_bvalid_o)
        else $error("write response late");
    AST_B_DONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response repeated");
    // Reads are taken within two cycles and answered in the next
    AST_AR_TAKE: assert property (s_axi_arvalid_i && !s_axi_rvalid_o && !s_axi_arready_o |->
        ##[1:2] s_axi_arready_o)
        else $error("read address not taken");
    AST_R_AFTER: assert property (s_axi_arready_o && s_axi_arvalid_i |=> s_axi_rvalid_o)
        else $error("read data late");
    // Unused bits read as zero
    AST_RD_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:3] == '0)
        else $error("unused read bits set");
endmodule : t1ts_sync_chk

`default_nettype wire
